// ===== hdl/comparator_output_control.sv
/*
 * Comparator output control: APB register file, reference and hysteresis
 * selection, timer-synchronised output latch, mismatch interrupt logic
 * and the digital port read with analog masking.
 * Assumes raw comparator results, the timer source clock and port pins are
 * asynchronous to clk; all pass a two flip-flop synchroniser first.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE1 - Shared register bit 7 mirrors comparator one, bit 6 comparator two.
// RULE2 - Reading the shared register never clears the mismatch latches.
// RULE3 - Reference source bit set picks fixed reference, cleared picks variable.
// RULE4 - Selected reference reaches the input only when the control register picks it.
// RULE5 - Hysteresis enable bits 3 and 2 turn hysteresis on per comparator.
// RULE6 - Sync mode bits 1 and 0 latch output on timer clock falling edge.
// RULE7 - With a prescaler, the falling edge comes from the prescaled clock.
// RULE8 - The timer counts on rising edges of its clock.
// RULE9 - Without sync mode the output follows the comparator result directly.
// RULE10 - Shared register resets to zero; mirrors read-only, six bits writable.
// RULE11 - Port reads return zero for pins configured as analog.
// RULE12 - Interrupt flag sets on the mismatch edge, not the mismatch level.
// RULE13 - Invert bit flips the reported output; mirrors show the adjusted value.
// RULE14 - In sync mode mirrors, mismatch and pin all use the latched value.
module comparator_output_control (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire comparator_pkg::apb_req_t apb_req,
    output comparator_pkg::apb_rsp_t apb_rsp,
    // Analog comparator cores
    input wire logic [1:0] comp_raw,
    output comparator_pkg::analog_ctrl_t analog_one,
    output comparator_pkg::analog_ctrl_t analog_two,
    // Timer clock source pin
    input wire logic timer_src,
    // Digital port pins
    input wire logic [7:0] port_pins,
    // Shared comparator output pin
    output logic comp_pin_out,
    output logic comp_pin_oe,
    // Interrupt
    output logic irq
);

    comparator_pkg::state_t state;
    comparator_pkg::state_t next_state;

    ////////////////////////////////////////////////////////////////////////
    // Decoding shared by the read and write paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, comparator_pkg::addr_control_one) ||
                 hit(addr, comparator_pkg::addr_control_two) ||
                 hit(addr, comparator_pkg::addr_shared) ||
                 hit(addr, comparator_pkg::addr_irq_status) ||
                 hit(addr, comparator_pkg::addr_irq_mask) ||
                 hit(addr, comparator_pkg::addr_timer_count) ||
                 hit(addr, comparator_pkg::addr_timer_config) ||
                 hit(addr, comparator_pkg::addr_port_value) ||
                 hit(addr, comparator_pkg::addr_analog_select);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Combinational views of state
    logic [7:0] control [2];
    logic [1:0] result;
    logic [1:0] effective;
    logic presc_clk;
    logic setup;
    logic access;
    logic is_write;

    assign control[0] = state.control_one;
    assign control[1] = state.control_two;
    assign setup = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable;
    assign is_write = access && apb_req.pwrite;

    // Polarity-adjusted results; an idle comparator shows its invert level
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_comp
            localparam int sync_pos = (g == 0) ? comparator_pkg::pos_sync_one : comparator_pkg::pos_sync_two;
            assign result[g] = control[g][comparator_pkg::pos_enable]
                ? (state.raw[g] ^ control[g][comparator_pkg::pos_invert]) // [RULE13]
                : control[g][comparator_pkg::pos_invert];
            assign effective[g] = state.shared[sync_pos] ? state.latched[g] // [RULE6] [RULE14]
                                                        : result[g];        // [RULE9]
        end
    endgenerate

    // Prescaled timer clock: divide-by 1, 2, 4 or 8 of the synchronised source
    always_comb begin
        unique case (state.timer_presc)
            2'h0: presc_clk = state.src;
            2'h1: presc_clk = state.presc_count[0];
            2'h2: presc_clk = state.presc_count[1];
            2'h3: presc_clk = state.presc_count[2];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic [31:0] rd;
        logic [1:0] mismatch;
        logic [1:0] w1c;
        rd = 32'h0000_0000;
        mismatch = 2'h0;
        w1c = 2'h0;
        next_state = state;

        // Synchronisers; first stages feed only the second stages
        next_state.raw_meta = comp_raw;
        next_state.raw = state.raw_meta;
        next_state.src_meta = timer_src;
        next_state.src = state.src_meta;
        next_state.src_prev = state.src;
        next_state.port_meta = port_pins;
        next_state.port = state.port_meta;

        // Prescaler advances on rising edges of the source clock
        if (state.src && !state.src_prev) begin
            next_state.presc_count = state.presc_count + 3'h1;
        end
        next_state.presc_prev = presc_clk;
        if (presc_clk && !state.presc_prev) begin
            next_state.timer = state.timer + 16'h0001; // [RULE8]
        end
        // Capture on the opposite edge so a count update never races the latch
        if (!presc_clk && state.presc_prev) begin
            next_state.latched = result; // [RULE6] [RULE7]
        end

        // Edge-triggered mismatch interrupt; set wins over a same-cycle clear
        mismatch = effective ^ state.mismatch_latch;
        next_state.mismatch_prev = mismatch;
        if (is_write && hit(apb_req.paddr, comparator_pkg::addr_irq_status)) begin
            w1c = apb_req.pwdata[1:0];
        end
        next_state.irq_status = (state.irq_status & ~w1c) | (mismatch & ~state.mismatch_prev); // [RULE12]

        // Read data prepared in the setup cycle, presented in the access cycle
        if (setup) begin
            if (hit(apb_req.paddr, comparator_pkg::addr_control_one)) begin
                rd[7:0] = state.control_one;
                rd[comparator_pkg::pos_result] = effective[0];
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_control_two)) begin
                rd[7:0] = state.control_two;
                rd[comparator_pkg::pos_result] = effective[1];
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_shared)) begin
                rd[5:0] = state.shared;
                rd[comparator_pkg::pos_mirror_one] = effective[0]; // [RULE1] [RULE14]
                rd[comparator_pkg::pos_mirror_two] = effective[1]; // [RULE1]
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_irq_status)) begin
                rd[1:0] = state.irq_status;
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_irq_mask)) begin
                rd[1:0] = state.irq_mask;
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_timer_count)) begin
                rd[15:0] = state.timer;
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_timer_config)) begin
                rd[1:0] = state.timer_presc;
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_port_value)) begin
                rd[7:0] = state.port & ~state.analog_select; // [RULE11]
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_analog_select)) begin
                rd[7:0] = state.analog_select;
            end
            next_state.read_data = rd;
        end

        // Any access to a control register, read or write, re-arms its latch
        if (access && hit(apb_req.paddr, comparator_pkg::addr_control_one)) begin
            next_state.mismatch_latch[0] = effective[0]; // [RULE2]
        end
        if (access && hit(apb_req.paddr, comparator_pkg::addr_control_two)) begin
            next_state.mismatch_latch[1] = effective[1]; // [RULE2]
        end

        // Writes; the result bit of the control registers is read-only
        if (is_write) begin
            if (hit(apb_req.paddr, comparator_pkg::addr_control_one)) begin
                next_state.control_one = apb_req.pwdata[7:0];
                next_state.control_one[comparator_pkg::pos_result] = 1'b0;
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_control_two)) begin
                next_state.control_two = apb_req.pwdata[7:0];
                next_state.control_two[comparator_pkg::pos_result] = 1'b0;
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_shared)) begin
                next_state.shared = apb_req.pwdata[5:0]; // [RULE10]
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_irq_mask)) begin
                next_state.irq_mask = apb_req.pwdata[1:0];
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_timer_count)) begin
                next_state.timer = apb_req.pwdata[15:0];
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_timer_config)) begin
                next_state.timer_presc = apb_req.pwdata[1:0];
            end
            if (hit(apb_req.paddr, comparator_pkg::addr_analog_select)) begin
                next_state.analog_select = apb_req.pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
            state.control_one <= comparator_pkg::reset_control;
            state.control_two <= comparator_pkg::reset_control;
            state.shared <= comparator_pkg::reset_shared; // [RULE10]
            state.timer <= comparator_pkg::reset_timer;
            state.analog_select <= comparator_pkg::reset_analog;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Zero-wait answer: read data was registered in the setup cycle
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access && !mapped(apb_req.paddr);
    assign apb_rsp.prdata = state.read_data;

    assign analog_one.enable = state.control_one[comparator_pkg::pos_enable];
    assign analog_one.high_speed = state.control_one[comparator_pkg::pos_speed];
    assign analog_one.hysteresis_en = state.shared[comparator_pkg::pos_hyst_one]; // [RULE5]
    assign analog_one.ref_input_select = state.control_one[comparator_pkg::pos_ref_input]; // [RULE4]
    assign analog_one.reference_output = state.shared[comparator_pkg::pos_ref_source_one]; // [RULE3]
    assign analog_one.channel = state.control_one[comparator_pkg::pos_channel +: 2];

    assign analog_two.enable = state.control_two[comparator_pkg::pos_enable];
    assign analog_two.high_speed = state.control_two[comparator_pkg::pos_speed];
    assign analog_two.hysteresis_en = state.shared[comparator_pkg::pos_hyst_two]; // [RULE5]
    assign analog_two.ref_input_select = state.control_two[comparator_pkg::pos_ref_input]; // [RULE4]
    assign analog_two.reference_output = state.shared[comparator_pkg::pos_ref_source_two]; // [RULE3]
    assign analog_two.channel = state.control_two[comparator_pkg::pos_channel +: 2];

    // One shared pin; comparator two takes it when both ask for it
    logic drive_one;
    logic drive_two;
    assign drive_one = state.control_one[comparator_pkg::pos_out_enable] &&
                       state.control_one[comparator_pkg::pos_enable];
    assign drive_two = state.control_two[comparator_pkg::pos_out_enable] &&
                       state.control_two[comparator_pkg::pos_enable];
    assign comp_pin_oe = drive_one || drive_two;
    assign comp_pin_out = drive_two ? effective[1] : effective[0]; // [RULE14]

    assign irq = |(state.irq_status & state.irq_mask);

endmodule

`default_nettype wire

// ===== inc/comparator_pkg.sv
/*
 * Constants and carrier types for the comparator output control block.
 * Assumes an APB master on the system clock and analog comparator cores
 * that take the selection levels and return one raw result bit each.
 */
`default_nettype none

package comparator_pkg;

    // Register byte addresses
    localparam logic [7:0] addr_control_one = 8'h00;
    localparam logic [7:0] addr_control_two = 8'h04;
    localparam logic [7:0] addr_shared = 8'h08;
    localparam logic [7:0] addr_irq_status = 8'h0c;
    localparam logic [7:0] addr_irq_mask = 8'h10;
    localparam logic [7:0] addr_timer_count = 8'h14;
    localparam logic [7:0] addr_timer_config = 8'h18;
    localparam logic [7:0] addr_port_value = 8'h1c;
    localparam logic [7:0] addr_analog_select = 8'h20;

    ////////////////////////////////////////////////////////////////////////
    // Per-comparator control register fields
    localparam int pos_enable = 7;
    localparam int pos_result = 6;
    localparam int pos_out_enable = 5;
    localparam int pos_invert = 4;
    localparam int pos_speed = 3;
    localparam int pos_ref_input = 2;
    localparam int pos_channel = 0;

    // Shared status and configuration register fields
    localparam int pos_mirror_one = 7;
    localparam int pos_mirror_two = 6;
    localparam int pos_ref_source_one = 5;
    localparam int pos_ref_source_two = 4;
    localparam int pos_hyst_one = 3;
    localparam int pos_hyst_two = 2;
    localparam int pos_sync_one = 1;
    localparam int pos_sync_two = 0;

    // Reset values
    localparam logic [7:0] reset_control = 8'h00;
    localparam logic [5:0] reset_shared = 6'h00;
    localparam logic [15:0] reset_timer = 16'h0000;
    localparam logic [7:0] reset_analog = 8'hff;

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    // Levels sent to one analog comparator core
    typedef struct packed {
        logic enable;
        logic high_speed;
        logic hysteresis_en;
        logic ref_input_select;
        logic reference_output;
        logic [1:0] channel;
    } analog_ctrl_t;

    typedef struct packed {
        logic [1:0] raw_meta;
        logic [1:0] raw;
        logic src_meta;
        logic src;
        logic src_prev;
        logic [7:0] port_meta;
        logic [7:0] port;
        logic [2:0] presc_count;
        logic presc_prev;
        logic [15:0] timer;
        logic [1:0] timer_presc;
        logic [7:0] control_one;
        logic [7:0] control_two;
        logic [5:0] shared;
        logic [1:0] latched;
        logic [1:0] mismatch_latch;
        logic [1:0] mismatch_prev;
        logic [1:0] irq_status;
        logic [1:0] irq_mask;
        logic [7:0] analog_select;
        logic [31:0] read_data;
    } state_t;

endpackage

`default_nettype wire

// ===== sim/comparator_analog_model.sv
/* Behavioural model of the two comparator cores and the timer clock source.
   Assumes the bench sets the pin and reference levels and asks for timer periods. */
`timescale 1ns/1ps
`default_nettype none
module comparator_analog_model (
    // Clock
    input wire logic clk,
    // Analog conditions set by the bench
    input wire logic [1:0] pin_level,
    input wire logic fixed_level,
    input wire logic var_level,
    // Levels from the block
    input wire comparator_pkg::analog_ctrl_t analog_one,
    input wire comparator_pkg::analog_ctrl_t analog_two,
    // Results and timer clock
    output logic [1:0] comp_raw,
    output logic timer_src
);
    // Hysteresis is not modelled: levels here never sit near the threshold
    function automatic logic judge(input comparator_pkg::analog_ctrl_t c, input logic prev, input logic pin);
        // A core that is off gives no steady level, so its output wanders
        if (!c.enable) return ~prev;
        if (!c.ref_input_select) return pin;
        return c.reference_output ? fixed_level : var_level;
    endfunction
    initial begin
        comp_raw = 2'b00;
        timer_src = 1'b0;
    end
    always @(posedge clk) begin
        comp_raw[0] <= judge(analog_one, comp_raw[0], pin_level[0]);
        comp_raw[1] <= judge(analog_two, comp_raw[1], pin_level[1]);
    end
    ////////////////////////////////////////
    // Timer source stands low between bursts; each period is 8 system clocks
    task automatic run_periods(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            timer_src <= 1'b1;
            repeat (4) @(posedge clk);
            timer_src <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ===== sim/comparator_output_control_monitor.sv
/* Port checker for the comparator output control block.
   Assumes one clock domain; bound to the design below. */
`timescale 1ns/1ps
`default_nettype none
module comparator_output_control_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Bus, cores and pins
    input wire comparator_pkg::apb_req_t apb_req,
    input wire comparator_pkg::apb_rsp_t apb_rsp,
    input wire logic [1:0] comp_raw,
    input wire comparator_pkg::analog_ctrl_t analog_one,
    input wire comparator_pkg::analog_ctrl_t analog_two,
    input wire logic timer_src,
    input wire logic [7:0] port_pins,
    input wire logic comp_pin_out,
    input wire logic comp_pin_oe,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic acc, wr, one_drives, moved, ts_q;
    logic [1:0] raw_q;
    logic [1:0] sync;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] ana;
    logic [2:0] quiet;
    assign acc = apb_req.psel && apb_req.penable;
    assign wr = acc && apb_req.pwrite;
    assign one_drives = ctl1[7] && ctl1[5] && !(ctl2[7] && ctl2[5]);
    // A control register access may reload a mismatch latch, so any access counts as movement
    assign moved = acc || timer_src != ts_q || |((comp_raw ^ raw_q) & {ctl2[7], ctl1[7]});
    always_ff @(posedge clk) begin
        raw_q <= comp_raw;
        ts_q <= timer_src;
        if (reset) begin
            ctl1 <= 8'h00;
            ctl2 <= 8'h00;
            ana <= 8'hff;
            sync <= 2'h0;
            quiet <= 3'h0;
        end else begin
            if (wr && apb_req.paddr == comparator_pkg::addr_control_one) ctl1 <= apb_req.pwdata[7:0];
            if (wr && apb_req.paddr == comparator_pkg::addr_control_two) ctl2 <= apb_req.pwdata[7:0];
            if (wr && apb_req.paddr == comparator_pkg::addr_analog_select) ana <= apb_req.pwdata[7:0];
            if (wr && apb_req.paddr == comparator_pkg::addr_shared) sync <= apb_req.pwdata[1:0];
            quiet <= moved ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
        end
    end
    ////////////////////////////////////////
    sequence s_shared_write;
        wr && apb_req.paddr == comparator_pkg::addr_shared;
    endsequence
    sequence s_clear_all;
        wr && apb_req.paddr == comparator_pkg::addr_irq_status && apb_req.pwdata[1:0] == 2'h3 && quiet >= 3'h5;
    endsequence
    a_reset_clean: assert property ($fell(reset) |-> analog_one == '0 && analog_two == '0 && !irq && !comp_pin_oe)
        else $error("Outputs not clear after reset");
    a_ref_source: assert property (s_shared_write |=> analog_one.reference_output == $past(apb_req.pwdata[5])
        && analog_two.reference_output == $past(apb_req.pwdata[4])) else $error("Reference source wrong");
    a_hyst_select: assert property (s_shared_write |=> analog_one.hysteresis_en == $past(apb_req.pwdata[3])
        && analog_two.hysteresis_en == $past(apb_req.pwdata[2])) else $error("Hysteresis select wrong");
    a_ref_input: assert property (wr && apb_req.paddr == comparator_pkg::addr_control_one
        |=> analog_one.ref_input_select == $past(apb_req.pwdata[2])) else $error("Reference input select wrong");
    a_async_pin: assert property (one_drives && !sync[1] |-> comp_pin_out == ($past(comp_raw[0], 2) ^ ctl1[4]))
        else $error("Pin does not follow comparator one");
    a_sync_hold: assert property (one_drives && sync[1] && quiet >= 3'h5 |-> $stable(comp_pin_out))
        else $error("Synchronised pin moved without a timer edge");
    a_clear_stays: assert property (s_clear_all |=> !irq)
        else $error("Interrupt set again by a steady mismatch");
    a_port_analog: assert property (acc && !apb_req.pwrite && apb_req.paddr == comparator_pkg::addr_port_value
        |-> (apb_rsp.prdata[7:0] & ana) == 8'h00 && apb_rsp.prdata[31:8] == 24'h0) else $error("Analog pin read as one");
endmodule
bind comparator_output_control comparator_output_control_monitor u_monitor (
    .clk, .reset, .apb_req, .apb_rsp, .comp_raw, .analog_one, .analog_two,
    .timer_src, .port_pins, .comp_pin_out, .comp_pin_oe, .irq
);
`default_nettype wire

// ===== sim/tb_comparator_output_control.sv
/* Self-checking bench for the comparator output control block.
   Assumes the analog model and the bound port checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_output_control;
    logic clk, reset, comp_pin_out, comp_pin_oe, irq, timer_src, fixed_level, var_level;
    logic [1:0] comp_raw;
    logic [1:0] pin_level;
    logic [7:0] port_pins, c, s, m;
    logic [31:0] seed = 32'h0b72d031;
    logic [31:0] v;
    logic [32:0] expq[$];
    comparator_pkg::apb_req_t req;
    comparator_pkg::apb_rsp_t rsp;
    comparator_pkg::analog_ctrl_t an_one, an_two;
    int num_errors = 0;
    int checks = 0;
    comparator_output_control u_dut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
        .comp_raw(comp_raw), .analog_one(an_one), .analog_two(an_two), .timer_src(timer_src),
        .port_pins(port_pins), .comp_pin_out(comp_pin_out), .comp_pin_oe(comp_pin_oe), .irq(irq));
    comparator_analog_model u_model (.clk(clk), .pin_level(pin_level), .fixed_level(fixed_level),
        .var_level(var_level), .analog_one(an_one), .analog_two(an_two), .comp_raw(comp_raw), .timer_src(timer_src));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk);
        req.penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk);
        end while (rsp.pready !== 1'b1);
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Reads only note the expectation; the watcher below compares
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err = 1'b0);
        expq.push_back({err, e});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    always @(posedge clk) begin
        if (req.psel && req.penable && !req.pwrite && expq.size() > 0) check({rsp.pslverr, rsp.prdata}, expq.pop_front());
    end
    // Whole run is under 1500 cycles; this limit only catches a hang
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        conclude();
    end
    ////////////////////////////////////////
    initial begin
        reset = 1'b1;
        req = '0;
        port_pins = 8'h00;
        pin_level = 2'b00;
        fixed_level = 1'b1;
        var_level = 1'b0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rd(comparator_pkg::addr_shared, 32'h00);
        rd(comparator_pkg::addr_analog_select, 32'hff);
        wr(comparator_pkg::addr_shared, 32'hffffffff);
        rd(comparator_pkg::addr_shared, 32'h3f);
        rd(8'h24, 32'h0, 1'b1);
        repeat (4) begin
            // Sync bits stay clear so the mirrors need no timer edge
            v = rnd() & 32'h3c;
            wr(comparator_pkg::addr_shared, v);
            rd(comparator_pkg::addr_shared, v);
        end
        for (int n = 0; n < 2; n++) begin
            c = n ? comparator_pkg::addr_control_two : comparator_pkg::addr_control_one;
            s = n ? 8'h10 : 8'h20;
            m = n ? 8'h40 : 8'h80;
            wr(comparator_pkg::addr_shared, s);
            wr(c, 8'ha4);
            idle(6);
            check({31'h0, comp_pin_oe, comp_pin_out}, 33'h3);
            rd(comparator_pkg::addr_shared, s | m);
            wr(comparator_pkg::addr_shared, 8'h00);
            idle(6);
            rd(comparator_pkg::addr_shared, 8'h00);
            wr(c, 8'hb4);
            idle(6);
            rd(comparator_pkg::addr_shared, m);
            wr(comparator_pkg::addr_shared, s);
            wr(c, 8'ha0);
            idle(6);
            rd(comparator_pkg::addr_shared, s);
            wr(c, 8'h00);
        end
        repeat (3) begin
            v = rnd();
            wr(comparator_pkg::addr_analog_select, {24'h0, v[7:0]});
            port_pins <= v[15:8];
            idle(4);
            rd(comparator_pkg::addr_port_value, {24'h0, v[15:8] & ~v[7:0]});
        end
        wr(comparator_pkg::addr_timer_config, 32'h3);
        wr(comparator_pkg::addr_control_one, 32'ha4);
        wr(comparator_pkg::addr_shared, 32'h02);
        idle(8);
        wr(comparator_pkg::addr_shared, 32'h22);
        idle(8);
        rd(comparator_pkg::addr_shared, 32'h22);
        u_model.run_periods(1);
        rd(comparator_pkg::addr_shared, 32'h22);
        u_model.run_periods(8);
        rd(comparator_pkg::addr_shared, 32'ha2);
        rd(comparator_pkg::addr_timer_count, 32'h1);
        wr(comparator_pkg::addr_timer_config, 32'h0);
        u_model.run_periods(3);
        rd(comparator_pkg::addr_timer_count, 32'h4);
        wr(comparator_pkg::addr_shared, 32'h0);
        wr(comparator_pkg::addr_control_one, 32'ha0);
        wr(comparator_pkg::addr_irq_mask, 32'h3);
        idle(6);
        rd(comparator_pkg::addr_control_one, 32'ha0);
        wr(comparator_pkg::addr_irq_status, 32'h3);
        rd(comparator_pkg::addr_irq_status, 32'h0);
        pin_level <= 2'b01;
        idle(6);
        check({32'h0, irq}, 33'h1);
        rd(comparator_pkg::addr_shared, 32'h80);
        idle(6);
        wr(comparator_pkg::addr_irq_status, 32'h3);
        idle(2);
        check({32'h0, irq}, 33'h0);
        pin_level <= 2'b00;
        idle(6);
        rd(comparator_pkg::addr_irq_status, 32'h0);
        pin_level <= 2'b01;
        idle(6);
        rd(comparator_pkg::addr_irq_status, 32'h1);
        wr(comparator_pkg::addr_irq_mask, 32'h0);
        idle(2);
        check({32'h0, irq}, 33'h0);
        idle(4);
        conclude();
    end
endmodule
`default_nettype wire
